// ---- dtf_ctrl_model.sv ----
// Controller model: frames training commands and drives write-FIFO beats.
// Assumes the block samples pins on the edge after this model launches them.
`timescale 1ns/1ps
`default_nettype none
module dtf_ctrl_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Requests from the bench
    input wire logic go,
    input wire logic [5:0] op,
    input wire logic [5:0] wl,
    input wire logic [17:0] wrBase,
    input wire logic ckeOff,
    // Command and write data pins
    output logic cke,
    output logic cmdCs,
    output logic [5:0] cmdCa,
    output logic [15:0] dqIn,
    output logic [1:0] maskInversionLaneIn,
    output logic busy
);
    logic [6:0] cnt;
    logic [6:0] beat;
    // Only the bench lowers clock enable
    assign cke = !ckeOff;
    assign busy = cnt != 7'h0;
    assign beat = cnt - 7'(wl) - 7'h05;

    // Head, operand, column head, zero operands, then beats; idle lanes toggle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 7'h0;
            cmdCs <= 1'b0;
            cmdCa <= 6'h0;
            {maskInversionLaneIn, dqIn} <= 18'h0;
        end
        else
        begin
            // One frame at a time, wider than any read, write or training spacing
            cnt <= (cnt == 7'(wl) + 7'h15) ? 7'h0 : (busy ? cnt + 7'h1 : 7'(go));
            cmdCs <= (!busy && go) || cnt == 7'h2;
            cmdCa <= cnt == 7'h1 ? op : (cnt == 7'h2 ? 6'h12 : ((!busy && go) ? 6'h20 : 6'h0));
            if (op == 6'h07 && beat < 7'h10)
                {maskInversionLaneIn, dqIn} <= wrBase + 18'(beat);
            else
                {maskInversionLaneIn, dqIn} <= ~{maskInversionLaneIn, dqIn};
        end
    end
endmodule : dtf_ctrl_model
`default_nettype wire

// ---- dtf_defs.svh ----
// Constants of the DRAM training FIFO and read DQ calibration block.
// Assumes a single 40 MHz clock domain and a classic Wishbone register port.
`ifndef DTF_DEFS_SVH
`define DTF_DEFS_SVH

// Register byte offsets
`define DTF_OFS_PAT_FIRST 8'h00
`define DTF_OFS_PAT_SECOND 8'h04
`define DTF_OFS_INV_MASK0 8'h08
`define DTF_OFS_INV_MASK1 8'h0c
`define DTF_OFS_TERM_CFG 8'h10
`define DTF_OFS_LATENCY 8'h14
`define DTF_OFS_MASK_CFG 8'h18
`define DTF_OFS_STATUS 8'h1c

// Reset values
`define DTF_RST_PAT_FIRST 8'h5a
`define DTF_RST_PAT_SECOND 8'h3c
`define DTF_RST_INV_MASK 8'h55
`define DTF_RST_TERM_CFG 3'h0
`define DTF_RST_RL 6'h06
`define DTF_RST_WL 6'h04
`define DTF_RST_MASK_CFG 3'h0

// Field positions
`define DTF_LAT_WL_LSB 8
`define DTF_STAT_RDPTR_LSB 4
`define DTF_STAT_WRCNT_LSB 8
`define DTF_STAT_ERR_BIT 16
`define DTF_STAT_BUSY_BIT 17

// Command encodings
`define DTF_MPC_HEAD 5'h00
`define DTF_CAS2_HEAD 5'h12
`define DTF_OP_RDFIFO 6'h01
`define DTF_OP_RDCAL 6'h03
`define DTF_OP_WRFIFO 6'h07

// Sizes and counts
`define DTF_FIFO_DEPTH 5
`define DTF_LAST_ENTRY 3'h4
`define DTF_BURST 16
`define DTF_LAST_BEAT 4'hf
`define DTF_LINE 64

`endif

// ---- dtf_pkg.sv ----
// Types of the DRAM training FIFO and read DQ calibration block.
// Assumes dtf_defs.svh for sizes.
`include "dtf_defs.svh"

package dtf_pkg;

    typedef enum logic [3:0] {
        CMD_IDLE = 4'b0001,
        CMD_MPC_OP = 4'b0010,
        CMD_CAS_HEAD = 4'b0100,
        CMD_CAS_TAIL = 4'b1000
    } dtf_cmd_t;

    typedef enum logic [1:0] {
        KIND_RDFIFO = 2'h0,
        KIND_RDCAL = 2'h1,
        KIND_WRFIFO = 2'h2
    } dtf_kind_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [7:0] patFirst;
        logic [7:0] patSecond;
        logic [7:0] invMask0;
        logic [7:0] invMask1;
        logic [2:0] termCfg;
        logic [5:0] readLat;
        logic [5:0] writeLat;
        logic [2:0] maskCfg;
        logic protoErr;
        dtf_cmd_t cmdState;
        logic op6;
        dtf_kind_t kind;
        logic [`DTF_LINE-1:0] rdFifoLine;
        logic [`DTF_LINE-1:0] rdCalLine;
        logic [`DTF_LINE-1:0] wrLine;
        logic [2:0] wrPtr;
        logic [2:0] rdPtr;
        logic [2:0] wrCount;
        logic [2:0] wrIdx;
        logic [2:0] rdIdx;
        logic [2:0] wrCur;
        logic [2:0] rdCur;
        logic wrActive;
        logic [3:0] wrPos;
        logic rdActive;
        logic rdCal;
        logic [3:0] rdPos;
        logic [`DTF_FIFO_DEPTH-1:0][`DTF_BURST-1:0][17:0] mem;
        logic [15:0] dqOut;
        logic dqOeN;
        logic [1:0] maskOut;
        logic maskOeN;
        logic readValid;
    } dtf_state_t;

endpackage : dtf_pkg

// ---- dtf_training.sv ----
// Training FIFO and read DQ calibration logic of a low-power DRAM channel.
// Assumes command, clock enable and data pins are sampled on the same clock as
// the controller drives them; one data beat per clock; registers over Wishbone.
// Notes on behaviour
// RQ1 - Write-FIFO accepted in any bank or refresh state while clock enable high.
// RQ2 - Repeated training commands need only the column-to-column spacing.
// RQ3 - Read-FIFO returns data with ordinary read latency and timing.
// RQ4 - Read pointer advances per read-FIFO, wraps after five; contents never corrupted.
// RQ5 - Read-FIFO of unwritten entries returns undefined data.
// RQ6 - Controller drives second-cycle column operands low after training commands.
// RQ7 - Mask/inversion lanes driven during read-FIFO when inversion or masking enabled.
// RQ8 - Controller waits read-to-training delay after read-FIFO before reads.
// RQ9 - Controller waits write-to-training delay after writes before write-FIFO.
// RQ10 - Only training mode writes between write-FIFO and read-FIFO; other pairs forbidden.
// RQ11 - Write to calibration and write-FIFO to read-FIFO spacing as computed.
// RQ12 - Read-to-training delay formula applies between reads and training commands.
// RQ13 - Read-FIFO to write-FIFO spacing without termination as computed.
// RQ14 - Read-FIFO to write-FIFO spacing with termination as computed.
// RQ15 - Calibration drives 16-bit pattern on all lanes, first register first.
// RQ16 - Calibration pattern inverted per data pin by two invert masks.
// RQ17 - Never invert mask lanes; no bus inversion during calibration.
// RQ18 - Each pattern byte sent least significant bit first.
// RQ19 - Mask zero bits map pins 0-7; mask one bits map pins 8-15.
// RQ20 - Operand 1000001b is read-FIFO, always a 16-beat burst.
// RQ21 - Separate five-entry circular write and read indices.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"

module dtf_training (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Wishbone slave
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [7:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    // Command bus
    input wire logic cke,
    input wire logic cmdCs,
    input wire logic [5:0] cmdCa,
    // Data lanes
    input wire logic [15:0] dqIn,
    input wire logic [1:0] maskInversionLaneIn,
    output logic [15:0] dqOut,
    output logic dqOeN,
    output logic [1:0] maskInversionLaneOut,
    output logic maskInversionLaneOeN,
    output logic readValid
);

    dtf_pkg::dtf_state_t s_reg;
    dtf_pkg::dtf_state_t s_next;

    // All next-state logic in one place
    always_comb
    begin
        logic busWrite;
        logic errSet;
        logic errClr;
        logic startRdFifo;
        logic startRdCal;
        logic startWr;
        logic rdFire;
        logic calFire;
        logic wrFire;
        logic patBit;
        logic [31:0] rdMux;
        busWrite = 1'b0;
        errSet = 1'b0;
        errClr = 1'b0;
        startRdFifo = 1'b0;
        startRdCal = 1'b0;
        startWr = 1'b0;
        rdFire = 1'b0;
        calFire = 1'b0;
        wrFire = 1'b0;
        patBit = 1'b0;
        rdMux = 32'h0000_0000;
        s_next = s_reg;

        // Wishbone: one wait state; a write lands at the edge where the master sees ack
        s_next.ack = wbCyc & wbStb & ~s_reg.ack;
        busWrite = wbCyc & wbStb & wbWe & s_reg.ack;
        if (busWrite && wbSel[0])
        begin
            if (wbAdr == `DTF_OFS_PAT_FIRST)
                s_next.patFirst = wbDatW[7:0];
            else if (wbAdr == `DTF_OFS_PAT_SECOND)
                s_next.patSecond = wbDatW[7:0];
            else if (wbAdr == `DTF_OFS_INV_MASK0)
                s_next.invMask0 = wbDatW[7:0];
            else if (wbAdr == `DTF_OFS_INV_MASK1)
                s_next.invMask1 = wbDatW[7:0];
            else if (wbAdr == `DTF_OFS_TERM_CFG)
                s_next.termCfg = wbDatW[2:0];
            else if (wbAdr == `DTF_OFS_LATENCY)
                s_next.readLat = wbDatW[5:0];
            else if (wbAdr == `DTF_OFS_MASK_CFG)
                s_next.maskCfg = wbDatW[2:0];
        end
        if (busWrite && wbSel[1] && wbAdr == `DTF_OFS_LATENCY)
            s_next.writeLat = wbDatW[`DTF_LAT_WL_LSB +: 6];
        errClr = busWrite && wbSel[2] && wbAdr == `DTF_OFS_STATUS && wbDatW[`DTF_STAT_ERR_BIT];

        // Read mux; unmapped offsets read zero
        if (wbAdr == `DTF_OFS_PAT_FIRST)
            rdMux = {24'h00_0000, s_reg.patFirst};
        else if (wbAdr == `DTF_OFS_PAT_SECOND)
            rdMux = {24'h00_0000, s_reg.patSecond};
        else if (wbAdr == `DTF_OFS_INV_MASK0)
            rdMux = {24'h00_0000, s_reg.invMask0};
        else if (wbAdr == `DTF_OFS_INV_MASK1)
            rdMux = {24'h00_0000, s_reg.invMask1};
        else if (wbAdr == `DTF_OFS_TERM_CFG)
            rdMux = {29'h0000_0000, s_reg.termCfg};
        else if (wbAdr == `DTF_OFS_LATENCY)
            rdMux = {18'h0_0000, s_reg.writeLat, 2'h0, s_reg.readLat};
        else if (wbAdr == `DTF_OFS_MASK_CFG)
            rdMux = {29'h0000_0000, s_reg.maskCfg};
        else if (wbAdr == `DTF_OFS_STATUS)
            rdMux = {14'h0000, s_reg.rdActive | s_reg.wrActive, s_reg.protoErr,
                     5'h00, s_reg.wrCount, 1'b0, s_reg.rdPtr, 1'b0, s_reg.wrPtr};
        s_next.rdata = (wbCyc & wbStb & ~s_reg.ack) ? rdMux : 32'h0000_0000;

        // Command decode; clock enable low abandons a sequence
        case (s_reg.cmdState)
            dtf_pkg::CMD_IDLE:
            begin
                if (cke && cmdCs && cmdCa[4:0] == `DTF_MPC_HEAD)
                begin
                    s_next.op6 = cmdCa[5];
                    s_next.cmdState = dtf_pkg::CMD_MPC_OP;
                end
            end
            dtf_pkg::CMD_MPC_OP:
            begin
                s_next.cmdState = dtf_pkg::CMD_IDLE;
                // Accepted whatever the bank or refresh state, only clock enable counts
                if (cke && s_reg.op6) // RQ1
                begin
                    if (cmdCa == `DTF_OP_RDFIFO) // RQ20
                    begin
                        s_next.kind = dtf_pkg::KIND_RDFIFO;
                        s_next.cmdState = dtf_pkg::CMD_CAS_HEAD;
                    end
                    else if (cmdCa == `DTF_OP_RDCAL)
                    begin
                        s_next.kind = dtf_pkg::KIND_RDCAL;
                        s_next.cmdState = dtf_pkg::CMD_CAS_HEAD;
                    end
                    else if (cmdCa == `DTF_OP_WRFIFO)
                    begin
                        s_next.kind = dtf_pkg::KIND_WRFIFO;
                        s_next.cmdState = dtf_pkg::CMD_CAS_HEAD;
                    end
                end
            end
            dtf_pkg::CMD_CAS_HEAD:
            begin
                s_next.cmdState = dtf_pkg::CMD_IDLE;
                if (cke && cmdCs && cmdCa[4:0] == `DTF_CAS2_HEAD)
                begin
                    errSet = cmdCa[5]; // RQ6
                    s_next.cmdState = dtf_pkg::CMD_CAS_TAIL;
                end
                else
                    errSet = 1'b1; // Column command missing: training dropped
            end
            dtf_pkg::CMD_CAS_TAIL:
            begin
                s_next.cmdState = dtf_pkg::CMD_IDLE;
                if (cke)
                begin
                    errSet = (cmdCa != 6'h00); // RQ6
                    startRdFifo = (s_reg.kind == dtf_pkg::KIND_RDFIFO);
                    startRdCal = (s_reg.kind == dtf_pkg::KIND_RDCAL);
                    startWr = (s_reg.kind == dtf_pkg::KIND_WRFIFO);
                end
            end
            default:
                s_next.cmdState = dtf_pkg::CMD_IDLE;
        endcase
        // Hardware set wins over a software clear in the same cycle
        s_next.protoErr = (s_reg.protoErr & ~errClr) | errSet;

        // Command-side indices move on every accepted read-FIFO or write-FIFO command
        if (startRdFifo)
            s_next.rdPtr = (s_reg.rdPtr == `DTF_LAST_ENTRY) ? 3'h0 : s_reg.rdPtr + 3'h1; // RQ4 RQ21
        if (startWr)
        begin
            s_next.wrPtr = (s_reg.wrPtr == `DTF_LAST_ENTRY) ? 3'h0 : s_reg.wrPtr + 3'h1; // RQ21
            if (s_reg.wrCount != `DTF_LAST_ENTRY + 3'h1)
                s_next.wrCount = s_reg.wrCount + 3'h1;
        end

        // Latency lines; each command rides its own bit so seamless commands overlap
        s_next.rdFifoLine = {s_reg.rdFifoLine[`DTF_LINE-2:0], startRdFifo};
        s_next.rdCalLine = {s_reg.rdCalLine[`DTF_LINE-2:0], startRdCal};
        s_next.wrLine = {s_reg.wrLine[`DTF_LINE-2:0], startWr};
        rdFire = s_reg.rdFifoLine[s_reg.readLat]; // RQ3
        calFire = s_reg.rdCalLine[s_reg.readLat]; // RQ3
        wrFire = s_reg.wrLine[s_reg.writeLat];

        // Read burst engine; a new burst at the last beat makes them seamless
        if (rdFire || calFire)
        begin
            s_next.rdActive = 1'b1;
            s_next.rdCal = calFire;
            s_next.rdPos = 4'h0; // RQ2
            if (rdFire)
            begin
                s_next.rdCur = s_reg.rdIdx;
                s_next.rdIdx = (s_reg.rdIdx == `DTF_LAST_ENTRY) ? 3'h0 : s_reg.rdIdx + 3'h1; // RQ4
            end
        end
        else if (s_reg.rdActive)
        begin
            s_next.rdPos = s_reg.rdPos + 4'h1;
            if (s_reg.rdPos == `DTF_LAST_BEAT) // RQ20
                s_next.rdActive = 1'b0;
        end

        // Write burst engine captures 16 beats into the chosen entry
        if (s_reg.wrActive)
        begin
            s_next.mem[s_reg.wrCur][s_reg.wrPos] = {maskInversionLaneIn, dqIn};
            s_next.wrPos = s_reg.wrPos + 4'h1;
            if (s_reg.wrPos == `DTF_LAST_BEAT)
                s_next.wrActive = 1'b0;
        end
        if (wrFire)
        begin
            s_next.wrActive = 1'b1;
            s_next.wrPos = 4'h0;
            s_next.wrCur = s_reg.wrIdx;
            s_next.wrIdx = (s_reg.wrIdx == `DTF_LAST_ENTRY) ? 3'h0 : s_reg.wrIdx + 3'h1; // RQ21
        end

        // Output beat; the FIFO is only read, so repeated reads keep it intact
        s_next.readValid = s_reg.rdActive;
        s_next.dqOeN = ~s_reg.rdActive;
        s_next.dqOut = 16'h0000;
        s_next.maskOut = 2'h0;
        s_next.maskOeN = 1'b1;
        if (s_reg.rdActive && s_reg.rdCal)
        begin
            // Low bit first, first pattern byte before the second
            patBit = s_reg.rdPos[3] ? s_reg.patSecond[s_reg.rdPos[2:0]] : s_reg.patFirst[s_reg.rdPos[2:0]]; // RQ15 RQ18
            for (int i = 0; i < 8; i++)
            begin
                s_next.dqOut[i] = patBit ^ s_reg.invMask0[i]; // RQ16 RQ19
                s_next.dqOut[i + 8] = patBit ^ s_reg.invMask1[i]; // RQ16 RQ19
            end
            // Mask lanes carry the raw pattern; read inversion is not applied
            s_next.maskOut = {patBit, patBit}; // RQ15 RQ17
            s_next.maskOeN = (s_reg.maskCfg == 3'h0);
        end
        else if (s_reg.rdActive)
        begin
            // Unwritten entries give whatever the storage holds
            s_next.dqOut = s_reg.mem[s_reg.rdCur][s_reg.rdPos][15:0]; // RQ5
            s_next.maskOut = s_reg.mem[s_reg.rdCur][s_reg.rdPos][17:16];
            s_next.maskOeN = (s_reg.maskCfg == 3'h0); // RQ7
        end
    end

    // State register; the FIFO storage clears on reset as well
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.patFirst <= `DTF_RST_PAT_FIRST;
            s_reg.patSecond <= `DTF_RST_PAT_SECOND;
            s_reg.invMask0 <= `DTF_RST_INV_MASK;
            s_reg.invMask1 <= `DTF_RST_INV_MASK;
            s_reg.termCfg <= `DTF_RST_TERM_CFG;
            s_reg.readLat <= `DTF_RST_RL;
            s_reg.writeLat <= `DTF_RST_WL;
            s_reg.maskCfg <= `DTF_RST_MASK_CFG;
            s_reg.cmdState <= dtf_pkg::CMD_IDLE;
            s_reg.kind <= dtf_pkg::KIND_RDFIFO;
            s_reg.dqOeN <= 1'b1;
            s_reg.maskOeN <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state register
    assign wbDatR = s_reg.rdata;
    assign wbAck = s_reg.ack;
    assign dqOut = s_reg.dqOut;
    assign dqOeN = s_reg.dqOeN;
    assign maskInversionLaneOut = s_reg.maskOut;
    assign maskInversionLaneOeN = s_reg.maskOeN;
    assign readValid = s_reg.readValid;

endmodule : dtf_training
`default_nettype wire

// ---- dtf_training_checker.sv ----
// Checker of dtf_training: bus handshake and read burst timing.
// Assumes read latency stays at its reset value of six cycles.
`timescale 1ns/1ps
`default_nettype none
module dtf_training_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register bus
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic [31:0] wbDatR,
    input wire logic wbAck,
    // Command and lanes
    input wire logic cke,
    input wire logic cmdCs,
    input wire logic [5:0] cmdCa,
    input wire logic dqOeN,
    input wire logic maskInversionLaneOeN,
    input wire logic readValid
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Fully framed read-type training command
    sequence trainRd;
        cke && cmdCs && cmdCa == 6'h20 ##1 cke && cmdCa inside {6'h01, 6'h03}
            ##1 cke && cmdCs && cmdCa == 6'h12 ##1 cke && cmdCa == 6'h00;
    endsequence

    // Bus answer one cycle after the take, for one cycle
    ack_after_take_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
        else $error("bus ack missing");
    ack_one_cycle_a: assert property (wbAck |=> !wbAck)
        else $error("bus ack held");
    rdata_idle_a: assert property (!wbAck |-> wbDatR == 32'h0)
        else $error("read data without ack");
    // Burst latency, length, cause and enables
    read_latency_a: assert property (trainRd |-> ##9 readValid && !dqOeN)
        else $error("burst late");
    burst_len_a: assert property ($rose(readValid) |-> readValid [*8] ##1 readValid [*8])
        else $error("burst short");
    burst_cause_a: assert property ($rose(readValid) |-> $past(cmdCa, 10) == 6'h12 && $past(cmdCs, 10))
        else $error("burst without command");
    oe_valid_a: assert property (readValid != dqOeN)
        else $error("data enable off burst");
    lane_quiet_a: assert property (!readValid |-> maskInversionLaneOeN)
        else $error("mask lanes driven idle");

    // Main scenarios reached
    cover property (trainRd);
    cover property ($fell(maskInversionLaneOeN));
    cover property (wbAck);
endmodule : dtf_training_checker

bind dtf_training dtf_training_checker chk_u (.clock, .rst, .wbCyc, .wbStb, .wbDatR, .wbAck, .cke, .cmdCs,
    .cmdCa, .dqOeN, .maskInversionLaneOeN, .readValid);
`default_nettype wire

// ---- dtf_training_tb.sv ----
// Testbench of dtf_training: registers, read calibration and training FIFO.
// Assumes the controller model owns the command and data pins.
`timescale 1ns/1ps
`default_nettype none
`include "dtf_defs.svh"
module dtf_training_tb;
    typedef struct packed {
        logic [7:0] pf;
        logic [7:0] ps;
        logic [7:0] m0;
        logic [7:0] m1;
        logic [2:0] lane;
        logic oeN;
    } dtf_row_t;
    // Pattern, masks, lane mode beside the expected lane enable
    dtf_row_t rows [4] = '{'{8'h5a, 8'h3c, 8'h55, 8'h55, 3'h0, 1'b1}, '{8'h1c, 8'h59, 8'h55, 8'h55, 3'h1, 1'b0},
        '{8'hff, 8'h00, 8'haa, 8'h0f, 3'h2, 1'b0}, '{8'h27, 8'hc8, 8'hf0, 8'h81, 3'h4, 1'b0}};
    logic [7:0] regAdr [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h20};
    logic [31:0] regRst [8] = '{32'h5a, 32'h3c, 32'h55, 32'h55, 32'h0, 32'h0406, 32'h0, 32'h0};
    logic clock, rst, wbCyc, wbStb, wbWe, wbAck, cke, cmdCs, dqOeN, maskInversionLaneOeN, readValid;
    logic go, ckeOff, busy, expLaneOeN;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rd;
    logic [5:0] cmdCa, op;
    logic [15:0] dqIn, dqOut;
    logic [1:0] maskInversionLaneIn, maskInversionLaneOut;
    logic [17:0] wrBase;
    logic [17:0] expBeat [16];
    int nFail, compares;

    dtf_training dut_u (.clock, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel, .wbDatW, .wbDatR, .wbAck, .cke,
        .cmdCs, .cmdCa, .dqIn, .maskInversionLaneIn, .dqOut, .dqOeN, .maskInversionLaneOut,
        .maskInversionLaneOeN, .readValid);
    dtf_ctrl_model mdl_u (.clock, .rst, .go, .op, .wl(6'h04), .wrBase, .ckeOff, .cke, .cmdCs, .cmdCa, .dqIn,
        .maskInversionLaneIn, .busy);

    // 40 MHz clock
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic conclude();
        $display("Compares %0d, mismatches %0d", compares, nFail);
        if (nFail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            nFail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A used-up wait ends the run
    task automatic guard(input int n);
        if (n >= 60)
        begin
            nFail++;
            conclude();
        end
    endtask : guard

    task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDatW <= dat;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (wbAck !== 1'b1 && n < 60);
        guard(n);
        rd = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wbXfer

    // One training command; read kinds compare all sixteen beats
    task automatic runCmd(input logic [5:0] opc, input logic [17:0] base);
        int n;
        logic rdOp;
        rdOp = opc != `DTF_OP_WRFIFO;
        @(posedge clock);
        go <= 1'b1;
        op <= opc;
        wrBase <= base;
        @(posedge clock);
        go <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (rdOp && readValid !== 1'b1 && n < 60);
        for (int k = 0; k < 16 && rdOp; k++)
        begin
            check(32'(dqOut), 32'(expBeat[k][15:0]));
            check(32'(maskInversionLaneOeN), 32'(expLaneOeN));
            if (!expLaneOeN)
                check(32'(maskInversionLaneOut), 32'(expBeat[k][17:16]));
            @(posedge clock);
        end
        while (busy === 1'b1 && n < 60)
        begin
            @(posedge clock);
            n++;
        end
        guard(n);
    endtask : runCmd

    function automatic logic [17:0] calBeat(input dtf_row_t r, input int k);
        logic b;
        b = k < 8 ? r.pf[k] : r.ps[k - 8];
        return {{2{b}}, {16{b}} ^ {r.m1, r.m0}};
    endfunction : calBeat

    initial
    begin
        rst = 1'b1;
        {wbCyc, wbStb, wbWe, go, ckeOff} = 5'h0;
        wbAdr = 8'h0;
        wbSel = 4'h0;
        wbDatW = 32'h0;
        op = 6'h0;
        wrBase = 18'h0;
        nFail = 0;
        compares = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        // Calibration pattern per row
        foreach (rows[i])
        begin
            wbXfer(1'b1, 8'h00, 32'(rows[i].pf));
            wbXfer(1'b1, 8'h04, 32'(rows[i].ps));
            wbXfer(1'b1, 8'h08, 32'(rows[i].m0));
            wbXfer(1'b1, 8'h0c, 32'(rows[i].m1));
            wbXfer(1'b1, 8'h18, 32'(rows[i].lane));
            for (int k = 0; k < 16; k++)
                expBeat[k] = calBeat(rows[i], k);
            expLaneOeN = rows[i].oeN;
            runCmd(`DTF_OP_RDCAL, 18'h0);
        end
        // Second reset in mid-run restores every register; unmapped reads zero
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        foreach (regAdr[i])
        begin
            wbXfer(1'b0, regAdr[i], 32'h0);
            check(rd, regRst[i]);
        end
        // Six writes: the sixth lands on entry zero; reads wrap after five
        wbXfer(1'b1, 8'h18, 32'h1);
        expLaneOeN = 1'b0;
        for (int w = 0; w < 6; w++)
            runCmd(`DTF_OP_WRFIFO, 18'(w) * 18'h0c731);
        wbXfer(1'b0, 8'h1c, 32'h0);
        check(rd, 32'h0501);
        for (int r = 0; r < 6; r++)
        begin
            for (int k = 0; k < 16; k++)
                expBeat[k] = 18'(r % 5 == 0 ? 5 : r % 5) * 18'h0c731 + 18'(k);
            runCmd(`DTF_OP_RDFIFO, 18'h0);
        end
        wbXfer(1'b0, 8'h1c, 32'h0);
        check(rd, 32'h0511);
        // Clock enable low drops a write-FIFO sequence
        ckeOff <= 1'b1;
        runCmd(`DTF_OP_WRFIFO, 18'h3ffff);
        ckeOff <= 1'b0;
        wbXfer(1'b0, 8'h1c, 32'h0);
        check(rd, 32'h0511);
        conclude();
    end
endmodule : dtf_training_tb
`default_nettype wire
